// ---- inc/dscp_cfg.svh ----
// Purpose: constants for the serial configuration port
// Assumes: 200 MHz system clock, serial clock sampled as data
// Notes: definitions only
`ifndef DSCP_CFG_SVH
`define DSCP_CFG_SVH
`define DSCP_ADDR_COMM      7'h00
`define DSCP_ADDR_FUPD      7'h36
`define DSCP_ADDR_FTW0      7'h30
`define DSCP_ADDR_FTW3      7'h33
`define DSCP_ADDR_PHS0      7'h34
`define DSCP_ADDR_PHS1      7'h35
`define DSCP_BIT_SDIO_BIDIR 7
`define DSCP_BIT_LSB_FIRST  6
`define DSCP_BIT_SOFT_RST   5
`define DSCP_BIT_FUPD       0
`define DSCP_ADDR_MIN       7'h00
`define DSCP_ADDR_MAX       7'h7F
`define DSCP_BITS_PER_BYTE  3'h7
`define DSCP_RST_BYTE       8'h00
`endif

// ---- inc/dscp_pkg.sv ----
// Purpose: types for the serial configuration port
// Assumes: nothing
// Notes: phases of one communication cycle
package dscp_pkg;
    typedef enum logic [0:0] {
        DSCP_PH_INSTR = 1'b0,
        DSCP_PH_DATA  = 1'b1
    } dscp_phase_t;
endpackage

// ---- rtl/dscp_sync.sv ----
// Purpose: two flip-flop synchroniser for one pin
// Assumes: input is asynchronous to clk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module dscp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dscp_port.sv ----
// Purpose: serial configuration port with 128-byte register file
// Assumes: serial clock far slower than clk; host is the only master
// Notes: writes land per byte; tuning/phase registers staged until update
// Notes on behaviour
// - The first eight rising serial clock edges shift in the instruction byte.
// - Instruction byte decides read or write and the first register address.
// - Chip select high then low restarts at the instruction phase.
// - Every later edge is data; one or many bytes may follow.
// - Each written byte updates its register at its last bit.
// - Tuning word and phase offset apply only when update bit is set.
// - Either one bidirectional data pin or separate input and output pins.
// - Bit order MSB-first or LSB-first, selected by a control bit.
// - Instruction bit 7 high means read; low seven bits give address.
// - Input sampled on rising edges, read data driven on falling edges.
// - Address steps down in MSB-first mode, up in LSB-first mode.
// - Both data pins float while chip select is high.
`timescale 1ns/1ps
`default_nettype none
`include "dscp_cfg.svh"
module dscp_port
    import dscp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe,
    output logic            serial_data_out_pin_o,
    output logic            serial_data_out_pin_oe,
    output logic            bidir_mode,
    output logic            lsb_first,
    output logic [31:0]     ftw_active,
    output logic [15:0]     phase_active,
    output logic            wr_strobe,
    output logic [6:0]      wr_addr,
    output logic [7:0]      wr_data
);
    logic        sclk_s;
    logic        cs_n_s;
    logic        sdi_s;
    logic        sclk_d_r;
    logic        cs_d_r;
    dscp_phase_t phase_r;
    logic [2:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic        rd_r;
    logic [6:0]  addr_r;
    logic [7:0]  tx_r;
    logic        out_bit_r;
    logic [7:0]  regs_r [0:127];

    dscp_sync #(.RST_VAL(1'b0)) u_sync_sclk (.clk(clk), .rst_n(rst_n), .ce(ce),
        .d(sclk), .q(sclk_s));
    dscp_sync #(.RST_VAL(1'b1)) u_sync_cs (.clk(clk), .rst_n(rst_n), .ce(ce),
        .d(cs_n), .q(cs_n_s));
    dscp_sync #(.RST_VAL(1'b0)) u_sync_sdi (.clk(clk), .rst_n(rst_n), .ce(ce),
        .d(sdio_i), .q(sdi_s));

    // Limitation: each serial clock half period must span about four clk
    // cycles, since two sync stages and the edge detector sit in front
    wire       sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
    wire       sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
    wire       cs_start  = cs_d_r & ~cs_n_s;
    wire       in_instr  = (phase_r == DSCP_PH_INSTR);
    wire       in_data   = (phase_r == DSCP_PH_DATA);
    wire       last_bit  = (bit_cnt_r == `DSCP_BITS_PER_BYTE);
    wire [2:0] cnt_nxt   = bit_cnt_r + 3'h1;
    wire       byte_done = sclk_rise && last_bit;
    // LSB-first fills from the top so the byte ends up in natural order
    wire [7:0] shift_nxt = lsb_first ? {sdi_s, shift_r[7:1]}
                                     : {shift_r[6:0], sdi_s};
    wire       instr_done = byte_done && in_instr;
    wire       data_done  = byte_done && in_data;
    wire       is_read    = shift_nxt[7];
    wire [6:0] start_addr = shift_nxt[6:0];
    // Saturate at the ends of the map rather than wrap
    wire [6:0] addr_step  = lsb_first
        ? ((addr_r == `DSCP_ADDR_MAX) ? addr_r : addr_r + 7'h01)
        : ((addr_r == `DSCP_ADDR_MIN) ? addr_r : addr_r - 7'h01);
    wire       do_write   = data_done && !rd_r;
    wire [6:0] rd_next    = instr_done ? start_addr : addr_step;
    wire       load_tx    = (instr_done && is_read) || (data_done && rd_r);
    wire       upd_req    = regs_r[`DSCP_ADDR_FUPD][`DSCP_BIT_FUPD];
    wire       fupd_wr    = do_write && (addr_r == `DSCP_ADDR_FUPD)
                            && shift_nxt[`DSCP_BIT_FUPD];
    wire       tx_bit     = lsb_first ? tx_r[0] : tx_r[7];
    wire [7:0] tx_shift   = lsb_first ? {1'b0, tx_r[7:1]}
                                      : {tx_r[6:0], 1'b0};
    // Output enable follows the synchronised select, so the pins float
    // a few clk cycles after the select pin rises
    wire       driving    = ~cs_n_s && rd_r && in_data;

    // Staged tuning and phase bytes, low byte at the lower address
    wire [7:0] ftw_b0     = regs_r[`DSCP_ADDR_FTW0];
    wire [7:0] ftw_b1     = regs_r[`DSCP_ADDR_FTW0 + 7'h01];
    wire [7:0] ftw_b2     = regs_r[`DSCP_ADDR_FTW3 - 7'h01];
    wire [7:0] ftw_b3     = regs_r[`DSCP_ADDR_FTW3];
    wire [7:0] phs_b0     = regs_r[`DSCP_ADDR_PHS0];
    wire [7:0] phs_b1     = regs_r[`DSCP_ADDR_PHS1];
    wire       apply_now  = upd_req || fupd_wr;

    assign bidir_mode = regs_r[`DSCP_ADDR_COMM][`DSCP_BIT_SDIO_BIDIR];
    assign lsb_first  = regs_r[`DSCP_ADDR_COMM][`DSCP_BIT_LSB_FIRST];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
        end else if (ce) begin
            sclk_d_r <= sclk_s;
            cs_d_r   <= cs_n_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r   <= DSCP_PH_INSTR;
            bit_cnt_r <= 3'h0;
            shift_r   <= `DSCP_RST_BYTE;
            rd_r      <= 1'b0;
            addr_r    <= `DSCP_ADDR_MIN;
        end else if (ce) begin
            if (cs_n_s || cs_start) begin
                phase_r   <= DSCP_PH_INSTR;
                bit_cnt_r <= 3'h0;
            end else if (sclk_rise) begin
                shift_r   <= shift_nxt;
                bit_cnt_r <= cnt_nxt;
                if (instr_done) begin
                    phase_r <= DSCP_PH_DATA;
                    rd_r    <= is_read;
                    addr_r  <= start_addr;
                end else if (data_done) begin
                    addr_r  <= addr_step;
                end
            end
        end
    end

    // Read byte loaded on the rising edge, shifted out from the next fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r      <= `DSCP_RST_BYTE;
            out_bit_r <= 1'b0;
        end else if (ce) begin
            if (load_tx) begin
                tx_r <= regs_r[rd_next];
            end else if (sclk_fall && driving) begin
                out_bit_r <= tx_bit;
                tx_r      <= tx_shift;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) begin
                regs_r[i] <= `DSCP_RST_BYTE;
            end
        end else if (ce) begin
            if (do_write) begin
                regs_r[addr_r] <= shift_nxt;
            end else if (upd_req) begin
                // Self-clearing so one write holds the update request for one cycle
                regs_r[`DSCP_ADDR_FUPD][`DSCP_BIT_FUPD] <= 1'b0;
            end
        end
    end

    // Staged values reach the datapath only on an update request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ftw_active   <= 32'h0000_0000;
            phase_active <= 16'h0000;
        end else if (ce && apply_now) begin
            // Applied on the update write itself and again the cycle after;
            // the second copy is harmless and keeps the clear path simple
            ftw_active   <= {ftw_b3, ftw_b2, ftw_b1, ftw_b0};
            phase_active <= {phs_b1, phs_b0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_strobe <= 1'b0;
            wr_addr   <= `DSCP_ADDR_MIN;
            wr_data   <= `DSCP_RST_BYTE;
        end else if (ce) begin
            wr_strobe <= do_write;
            if (do_write) begin
                wr_addr <= addr_r;
                wr_data <= shift_nxt;
            end
        end
    end

    assign sdio_o                 = out_bit_r;
    assign sdio_oe                = driving && bidir_mode;
    assign serial_data_out_pin_o  = out_bit_r;
    assign serial_data_out_pin_oe = driving && !bidir_mode;
endmodule
`default_nettype wire

// ---- dv/dscp_port_sva.sv ----
// Purpose: pin and register checks for dscp_port
// Assumes: pins reach the core through a 2 FF sync
// Notes: windows allow for that sync delay
`timescale 1ns/1ps
`default_nettype none
module dscp_port_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        sdio_o,
    input wire logic        sdio_oe,
    input wire logic        serial_data_out_pin_o,
    input wire logic        serial_data_out_pin_oe,
    input wire logic        bidir_mode,
    input wire logic        lsb_first,
    input wire logic [31:0] ftw_active,
    input wire logic [15:0] phase_active,
    input wire logic        wr_strobe,
    input wire logic [6:0]  wr_addr,
    input wire logic [7:0]  wr_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic upd;
    logic md;
    assign upd = wr_strobe && wr_addr == 7'h36 && wr_data[0];
    assign md = wr_strobe && wr_addr == 7'h00;
    oe_float_a: assert property (cs_n [*5] |-> !sdio_oe && !serial_data_out_pin_oe)
        else $error("pin driven while deselected");
    oe_excl_a: assert property (!(sdio_oe && serial_data_out_pin_oe))
        else $error("both pins driven");
    sdio_mode_a: assert property (sdio_oe |-> bidir_mode) else $error("sdio oe");
    sdo_mode_a: assert property (serial_data_out_pin_oe |-> !bidir_mode)
        else $error("sdo oe");
    same_bit_a: assert property (sdio_o == serial_data_out_pin_o) else $error("bit");
    strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe) else $error("strobe");
    // Apply lands with the strobe and repeats a cycle later
    tune_hold_a: assert property (!(upd || $past(upd) || $past(upd, 2)) |->
        $stable(ftw_active) && $stable(phase_active)) else $error("tuning moved");
    mode_write_a: assert property (md |-> ##[0:1]
        {bidir_mode, lsb_first} == wr_data[7:6]) else $error("mode bits");
    cover property (upd);
    cover property (sdio_oe);
    cover property (serial_data_out_pin_oe);
endmodule
bind dscp_port dscp_port_sva u_dscp_port_sva (.clk, .rst_n, .cs_n, .sdio_o, .sdio_oe,
    .serial_data_out_pin_o, .serial_data_out_pin_oe, .bidir_mode, .lsb_first,
    .ftw_active, .phase_active, .wr_strobe, .wr_addr, .wr_data);
`default_nettype wire

// ---- dv/dscp_host.sv ----
// Purpose: serial host model driving the port pins
// Assumes: 80 ns serial clock, idle low between frames
// Notes: lsb and bd track the port's mode bits
`timescale 1ns/1ps
`default_nettype none
module dscp_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_i,
    input  wire logic sdio_o,
    input  wire logic sdio_oe,
    input  wire logic sdo_o,
    input  wire logic sdo_oe
);
    logic lsb = 1'b0;
    logic bd = 1'b0;
    logic h_oe = 1'b1;
    logic h_d = 1'b0;
    logic pin;
    // Undriven line shows the inverse, never a stale level
    assign sdio_i = sdio_oe ? sdio_o : h_oe ? h_d : ~h_d;
    assign pin = bd ? sdio_i : sdo_oe ? sdo_o : ~sdo_o;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    task automatic bytex(input logic [7:0] b, input int nb, output logic [7:0] r);
        int k;
        r = 8'h00;
        for (int i = 0; i < nb; i++) begin
            k = lsb ? i : 7 - i;
            h_d = b[k];
            #40 sclk = 1'b1;
            r[k] = pin;
            #40 sclk = 1'b0;
        end
    endtask
    // Last byte may be cut short to abort
    task automatic frame(input logic rd, input logic [6:0] a, input int n, input int nb,
                         input logic [63:0] w, output logic [63:0] r);
        logic [7:0] x;
        r = 64'h0;
        cs_n = 1'b0;
        #40 bytex({rd, a}, 8, x);
        h_oe = !(rd && bd);
        for (int j = 0; j < n; j++) begin
            bytex(w[8*j+:8], j == n - 1 ? nb : 8, x);
            r[8*j+:8] = x;
        end
        h_oe = 1'b1;
        cs_n = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// ---- dv/dscp_port_tb.sv ----
// Purpose: directed frames through the host model
// Assumes: 200 MHz clk, serial pins asynchronous
// Notes: ce held high throughout
`timescale 1ns/1ps
`default_nettype none
module dscp_port_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        sclk, cs_n, sdio_i, sdio_o, sdio_oe, so_o, so_oe, bdm, lsbm, stb;
    logic [31:0] ftw;
    logic [15:0] phs;
    logic [6:0]  wa, la;
    logic [7:0]  wd;
    logic [63:0] r;
    int          n_fail = 0;
    int          num_checks = 0;
    int          ns = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    dscp_port u_dscp_port (.clk, .rst_n, .ce, .sclk, .cs_n, .sdio_i, .sdio_o, .sdio_oe,
        .serial_data_out_pin_o(so_o), .serial_data_out_pin_oe(so_oe), .bidir_mode(bdm),
        .lsb_first(lsbm), .ftw_active(ftw), .phase_active(phs), .wr_strobe(stb),
        .wr_addr(wa), .wr_data(wd));
    dscp_host u_dscp_host (.sclk, .cs_n, .sdio_i, .sdio_o, .sdio_oe, .sdo_o(so_o),
        .sdo_oe(so_oe));
    always @(posedge clk) begin
        if (stb === 1'b1) begin
            ns <= ns + 1;
            la <= wa;
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge clk);
        u_dscp_host.frame(1'b0, 7'h12, 3, 8, 64'hC3B2A1, r);
        chk("strobes", 3, ns);
        chk("last addr", 7'h10, la);
        u_dscp_host.frame(1'b1, 7'h12, 3, 8, 64'h0, r);
        chk("read msb", 64'hC3B2A1, r);
        u_dscp_host.frame(1'b0, 7'h20, 2, 4, 64'h5A77, r);
        chk("abort strobes", 4, ns);
        u_dscp_host.frame(1'b1, 7'h20, 2, 8, 64'h0, r);
        chk("after abort", 64'h0077, r);
        u_dscp_host.frame(1'b0, 7'h00, 1, 8, 64'h40, r);
        chk("lsb_first", 1, lsbm);
        u_dscp_host.lsb = 1'b1;
        u_dscp_host.frame(1'b0, 7'h7E, 3, 8, 64'h332211, r);
        chk("top addr", 7'h7F, la);
        u_dscp_host.frame(1'b1, 7'h7E, 2, 8, 64'h0, r);
        chk("read lsb", 64'h3311, r);
        u_dscp_host.frame(1'b0, 7'h30, 6, 8, 64'h665544332211, r);
        chk("ftw staged", 0, {phs, ftw});
        u_dscp_host.frame(1'b0, 7'h36, 1, 8, 64'h01, r);
        chk("ftw applied", 48'h665544332211, {phs, ftw});
        u_dscp_host.frame(1'b0, 7'h00, 1, 8, 64'hC0, r);
        chk("bidir", 1, bdm);
        u_dscp_host.bd = 1'b1;
        u_dscp_host.frame(1'b1, 7'h30, 2, 8, 64'h0, r);
        chk("read bidir", 64'h2211, r);
        wrap_up;
    end
endmodule
`default_nettype wire
